// *** logic/eit_pkg.sv ***
// Purpose: Shared constants and types of the two-wire memory target front end
// Assumes: One system clock domain plus the serial clock domain
// Notes:   Phase codes follow a Gray walk along the usual transfer path
package eit_pkg;

  // Device type field; value is arbitrary, set per product
  localparam logic [3:0] EIT_DEV_TYPE  = 4'h5;

  // Bit slot counter within one nine-slot byte frame
  localparam logic [3:0] EIT_BIT_LAST  = 4'h7;
  localparam logic [3:0] EIT_BIT_ACK   = 4'h8;

  // Pin vector layout of the synchronised inputs
  localparam int         EIT_PIN_W     = 6;
  localparam int         EIT_PIN_SCL   = 0;
  localparam int         EIT_PIN_SDA   = 1;
  localparam int         EIT_PIN_WP    = 2;
  localparam int         EIT_PIN_STRAP = 3;

  // Idle bus level after reset: both lines high, protect low
  localparam logic [5:0] EIT_PIN_RESET = 6'h03;

  // Transfer phase
  typedef enum logic [2:0] {
    EIT_IDLE    = 3'h0,
    EIT_SEL     = 3'h1,
    EIT_ADDR_HI = 3'h3,
    EIT_ADDR_LO = 3'h2,
    EIT_WDATA   = 3'h6,
    EIT_RDATA   = 3'h7
  } eit_phase_type;

  // One accepted write byte with its location
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
  } eit_wr_type;

  // Front end state seen by the memory core
  typedef struct packed {
    eit_phase_type phase;
    logic          selected;
    logic          read_dir;
    logic          protect;
  } eit_status_type;

endpackage

// *** logic/eit_target.sv ***
// Purpose: Two-wire serial target front end of a serial memory
// Assumes: clk_sys far faster than the serial clock; memory core outside
// Notes:   Bits are captured on the serial clock itself, framing and
//          answers are handled on clk_sys from filtered pin copies
`timescale 1ns/1ps
`default_nettype none

module eit_target
(
  // System clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    resetn,
  // Serial clock pin, as clock and as level
  input  wire logic                    scl_clk,
  input  wire logic                    scl_i,
  // Serial data pin, open drain
  input  wire logic                    sda_i,
  output logic                         sda_o,
  output logic                         sda_oe,
  // Straps and protect pins
  input  wire logic                    write_protect_n,
  input  wire logic                    chip_sel_strap_2,
  input  wire logic                    chip_sel_strap_1,
  input  wire logic                    chip_sel_strap_0,
  // Memory core side
  input  wire logic                    wr_busy,
  input  wire logic [7:0]              rd_data,
  output logic                         rd_next,
  output logic                         addr_load,
  output logic                         wr_valid,
  output eit_pkg::eit_wr_type          wr_out,
  output logic                         wr_cycle_start,
  output eit_pkg::eit_status_type      status
);
  import eit_pkg::*;

  // Serial clock domain: last sampled bit and event toggle
  logic                 link_bit_q;
  logic                 link_tog_q;
  // Toggle synchroniser into clk_sys
  logic                 tog_s1_q;
  logic                 tog_s2_q;
  logic                 tog_s3_q;
  // Pin synchronisers and filtered levels
  logic [EIT_PIN_W-1:0] pin_raw;
  logic [EIT_PIN_W-1:0] pin_s1_q;
  logic [EIT_PIN_W-1:0] pin_s2_q;
  logic [EIT_PIN_W-1:0] pin_s3_q;
  logic [EIT_PIN_W-1:0] pin_f_q;
  logic [EIT_PIN_W-1:0] pin_f_d;
  // Previous filtered bus levels
  logic                 scl_prev_q;
  logic                 sda_prev_q;
  // Bus events
  logic                 scl_f;
  logic                 sda_f;
  logic                 start_ev;
  logic                 stop_ev;
  logic                 fall_ev;
  logic                 rise_ev;
  logic                 protect;
  logic [2:0]           straps;
  logic [7:0]           byte_full;
  logic                 sel_match;
  // Transfer state
  eit_phase_type        phase_q;
  logic [3:0]           bitcnt_q;
  logic [6:0]           rx_q;
  logic                 ack_en_q;
  logic                 read_dir_q;
  logic                 data_seen_q;
  // Outputs and data path
  logic [7:0]           rd_byte_q;
  logic [15:0]          addr_q;
  logic                 sda_oe_q;
  logic                 rd_next_q;
  logic                 addr_load_q;
  logic                 wr_valid_q;
  eit_wr_type           wr_q;
  logic                 wr_start_q;
  eit_status_type       status_q;

  // Sample data on every serial clock rise
  always_ff @(posedge scl_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      link_bit_q <= 1'b1;
      link_tog_q <= 1'b0;
    end
    else
    begin
      link_bit_q <= sda_i;
      link_tog_q <= ~link_tog_q;
    end
  end

  // Toggle crossing; the bit stays still for a whole serial clock period
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
      tog_s3_q <= 1'b0;
    end
    else
    begin
      tog_s1_q <= link_tog_q;
      tog_s2_q <= tog_s1_q;
      tog_s3_q <= tog_s2_q;
    end
  end

  assign rise_ev = tog_s2_q ^ tog_s3_q;

  // Pin vector, strap order 0..2 upward
  assign pin_raw = {chip_sel_strap_2, chip_sel_strap_1, chip_sel_strap_0,
                    write_protect_n, sda_i, scl_i};

  // Three-stage pin synchroniser
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_s1_q <= EIT_PIN_RESET;
      pin_s2_q <= EIT_PIN_RESET;
      pin_s3_q <= EIT_PIN_RESET;
    end
    else
    begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // A change counts only once stages two and three agree
  assign pin_f_d = (pin_s2_q & ~(pin_s2_q ^ pin_s3_q))
                 | (pin_f_q & (pin_s2_q ^ pin_s3_q));

  // Filtered levels and the previous clock and data values
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_f_q    <= EIT_PIN_RESET;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else
    begin
      pin_f_q    <= pin_f_d;
      scl_prev_q <= pin_f_q[EIT_PIN_SCL];
      sda_prev_q <= pin_f_q[EIT_PIN_SDA];
    end
  end

  assign scl_f   = pin_f_q[EIT_PIN_SCL];
  assign sda_f   = pin_f_q[EIT_PIN_SDA];
  // A floating protect pin must be pulled low on the board
  assign protect = pin_f_q[EIT_PIN_WP];
  assign straps  = pin_f_q[EIT_PIN_STRAP+:3];

  // Framing conditions need the clock high on both samples
  assign start_ev = scl_f & scl_prev_q & sda_prev_q & ~sda_f;
  assign stop_ev  = scl_f & scl_prev_q & ~sda_prev_q & sda_f;
  assign fall_ev  = scl_prev_q & ~scl_f;

  // Whole byte at the eighth rise, first bit in the top position
  assign byte_full = {rx_q, link_bit_q};
  assign sel_match = (byte_full[7:4] == EIT_DEV_TYPE)
                   & (byte_full[3:1] == straps);

  // Transfer phase and bit slot tracking
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      phase_q     <= EIT_IDLE;
      bitcnt_q    <= 4'h0;
      rx_q        <= 7'h00;
      ack_en_q    <= 1'b0;
      read_dir_q  <= 1'b0;
      data_seen_q <= 1'b0;
    end
    else if (wr_busy)
    begin
      // Bus ignored while the array is being written
      phase_q  <= EIT_IDLE;
      bitcnt_q <= 4'h0;
    end
    else if (start_ev)
    begin
      // Start or repeated start opens a new select byte
      phase_q     <= EIT_SEL;
      bitcnt_q    <= 4'h0;
      ack_en_q    <= 1'b0;
      data_seen_q <= 1'b0;
    end
    else if (stop_ev)
    begin
      // Stop always ends the transfer
      phase_q  <= EIT_IDLE;
      bitcnt_q <= 4'h0;
    end
    else if (rise_ev && phase_q != EIT_IDLE)
    begin
      if (bitcnt_q == EIT_BIT_ACK)
      begin
        // Ninth slot done: move on
        bitcnt_q <= 4'h0;
        case (phase_q)
          EIT_SEL:
          begin
            if (!ack_en_q)
              phase_q <= EIT_IDLE;
            else if (read_dir_q)
              phase_q <= EIT_RDATA;
            else
              phase_q <= EIT_ADDR_HI;
          end
          EIT_ADDR_HI:
            phase_q <= EIT_ADDR_LO;
          EIT_ADDR_LO:
            phase_q <= EIT_WDATA;
          EIT_WDATA:
          begin
            if (ack_en_q)
              data_seen_q <= 1'b1;
          end
          EIT_RDATA:
          begin
            // Controller left data high: no more bytes
            if (link_bit_q)
              phase_q <= EIT_IDLE;
          end
          default:
            phase_q <= EIT_IDLE;
        endcase
      end
      else
      begin
        rx_q     <= byte_full[6:0];
        bitcnt_q <= bitcnt_q + 4'h1;
        if (bitcnt_q == EIT_BIT_LAST)
        begin
          // Decide the answer for the coming ninth slot
          case (phase_q)
            EIT_SEL:
            begin
              ack_en_q   <= sel_match;
              read_dir_q <= link_bit_q;
            end
            EIT_ADDR_HI,
            EIT_ADDR_LO:
              ack_en_q <= 1'b1;
            EIT_WDATA:
              ack_en_q <= ~protect;
            default:
              ack_en_q <= 1'b0;
          endcase
        end
      end
    end
  end

  // Address, write data and read data handling
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      addr_q      <= 16'h0000;
      addr_load_q <= 1'b0;
      wr_valid_q  <= 1'b0;
      wr_q        <= '0;
      rd_byte_q   <= 8'hff;
      rd_next_q   <= 1'b0;
    end
    else
    begin
      addr_load_q <= 1'b0;
      wr_valid_q  <= 1'b0;
      rd_next_q   <= 1'b0;
      if (rise_ev && !wr_busy && !start_ev && !stop_ev)
      begin
        if (bitcnt_q == EIT_BIT_LAST)
        begin
          case (phase_q)
            EIT_ADDR_HI:
              addr_q[15:8] <= byte_full;
            EIT_ADDR_LO:
            begin
              addr_q[7:0] <= byte_full;
              addr_load_q <= 1'b1;
            end
            EIT_WDATA:
            begin
              // Protected bytes never leave the front end
              if (!protect)
              begin
                wr_q       <= '{addr: addr_q, data: byte_full};
                wr_valid_q <= 1'b1;
                addr_q     <= addr_q + 16'h0001;
              end
            end
            default:
              addr_q <= addr_q;
          endcase
        end
        else if (bitcnt_q == EIT_BIT_ACK)
        begin
          // Fetch the next byte to send; protect plays no part
          if ((phase_q == EIT_SEL && ack_en_q && read_dir_q)
              || (phase_q == EIT_RDATA && !link_bit_q))
          begin
            rd_byte_q <= rd_data;
            rd_next_q <= 1'b1;
          end
        end
      end
    end
  end

  // Stop's own clock rise is slot one of the next byte, so check one
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      wr_start_q <= 1'b0;
    else
      wr_start_q <= stop_ev && !wr_busy && phase_q == EIT_WDATA
                    && bitcnt_q == 4'h1 && data_seen_q;
  end

  // Data line drive, set only after the serial clock falls; busy, start, stop or idle release it at once
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      sda_oe_q <= 1'b0;
    else if (wr_busy || start_ev || stop_ev || phase_q == EIT_IDLE)
      sda_oe_q <= 1'b0;
    else if (fall_ev)
    begin
      if (bitcnt_q == EIT_BIT_ACK)
        sda_oe_q <= ack_en_q;
      else if (phase_q == EIT_RDATA)
        sda_oe_q <= ~rd_byte_q[~bitcnt_q[2:0]];
      else
        sda_oe_q <= 1'b0;
    end
  end

  // Status snapshot for the memory core
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      status_q <= '{phase: EIT_IDLE, selected: 1'b0,
                    read_dir: 1'b0, protect: 1'b0};
    else
      status_q <= '{phase: phase_q,
                    selected: phase_q != EIT_IDLE && phase_q != EIT_SEL,
                    read_dir: read_dir_q, protect: protect};
  end

  // Open drain: only ever pulls low
  assign sda_o          = 1'b0;
  assign sda_oe         = sda_oe_q;
  assign rd_next        = rd_next_q;
  assign addr_load      = addr_load_q;
  assign wr_valid       = wr_valid_q;
  assign wr_out         = wr_q;
  assign wr_cycle_start = wr_start_q;
  assign status         = status_q;

endmodule

`default_nettype wire

// *** verification/eit_target_props.sv ***
// Purpose: Port checks of the two-wire memory target front end
// Assumes: Bench serial clock far slower than clk_sys
// Notes:   One domain; reset disables all but the reset check
`timescale 1ns/1ps
`default_nettype none
module eit_target_props
(
  // System clock and reset
  input wire logic                   clk_sys,
  input wire logic                   resetn,
  // Bus pins, raw levels
  input wire logic                   scl_i,
  input wire logic                   sda_i,
  input wire logic                   sda_oe,
  input wire logic                   write_protect_n,
  // Memory core side
  input wire logic                   wr_busy,
  input wire logic                   rd_next,
  input wire logic                   wr_valid,
  input wire logic                   wr_cycle_start,
  input wire eit_pkg::eit_status_type status
);
  import eit_pkg::*;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // Both lines released and high
  sequence s_bus_idle;
    scl_i && sda_i;
  endsequence

  // Pull held through most of a low phase
  sequence s_oe_held;
    sda_oe [*8];
  endsequence

  // Reset must win even mid-transfer, so no disable here
  property p_rst_quiet;
    disable iff (1'b0) !resetn |-> !sda_oe && status.phase == EIT_IDLE;
  endproperty
  // Device only starts pulling the data line while the clock is low
  property p_oe_low_clk;
    $rose(sda_oe) |-> !scl_i;
  endproperty
  property p_oe_hold;
    $rose(sda_oe) |-> s_oe_held;
  endproperty
  // Busy write cycle: bus ignored
  property p_busy_quiet;
    wr_busy [*8] |-> !sda_oe && !wr_valid;
  endproperty
  property p_wp_block;
    write_protect_n && $past(write_protect_n, 8) |-> !wr_valid && !wr_cycle_start;
  endproperty
  property p_cycle_on_stop;
    wr_cycle_start |-> s_bus_idle;
  endproperty
  property p_rd_dir;
    rd_next |-> status.read_dir;
  endproperty
  property p_wr_dir;
    wr_valid |-> !status.read_dir && !write_protect_n;
  endproperty
  // Idle phase never pulls the line
  property p_idle_rel;
    (status.phase == EIT_IDLE) [*2] |-> !sda_oe;
  endproperty

  a_rst_quiet: assert property (p_rst_quiet) else $error("line pulled in reset");
  a_oe_low_clk: assert property (p_oe_low_clk) else $error("pull while clock high");
  a_oe_hold: assert property (p_oe_hold) else $error("pull dropped early");
  a_busy_quiet: assert property (p_busy_quiet) else $error("answer while busy");
  a_wp_block: assert property (p_wp_block) else $error("write under protect");
  a_cycle_on_stop: assert property (p_cycle_on_stop) else $error("cycle not at stop");
  a_rd_dir: assert property (p_rd_dir) else $error("read step in write");
  a_wr_dir: assert property (p_wr_dir) else $error("write byte in read");
  a_idle_rel: assert property (p_idle_rel) else $error("pull while idle");
endmodule
`default_nettype wire

// *** verification/eit_bus_ctrl.sv ***
// Purpose: Behavioural two-wire bus controller for the target bench
// Assumes: Open drain data line with pull-up resolved by the bench
// Notes:   Clock rests high between frames; phases off the clk_sys grid
`timescale 1ns/1ps
`default_nettype none
module eit_bus_ctrl
(
  // Controller drives
  output logic      scl,
  output logic      sda_pull,
  // Resolved data line
  input  wire logic sda
);
  // Quarter and high phase lengths in ns
  localparam int Q = 61;
  localparam int H = 133;

  // Idle: clock high, line released
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // Start: line falls under high clock
  task automatic bus_start();
    sda_pull = 1'b1;
    #H scl = 1'b0;
    #Q;
  endtask

  // Byte out, top bit first, then ack slot
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      sda_pull = !b[i];
      #Q scl = 1'b1;
      #H scl = 1'b0;
      #Q;
    end
    sda_pull = 1'b0;
    #Q scl = 1'b1;
    #(H / 2) ack = !sda;
    #(H - H / 2) scl = 1'b0;
    #Q;
  endtask

  // Byte in; ack_it low leaves the ninth slot high
  task automatic get_byte(input logic ack_it, output logic [7:0] b);
    sda_pull = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      #Q scl = 1'b1;
      #(H / 2) b[i] = sda;
      #(H - H / 2) scl = 1'b0;
      #Q;
    end
    sda_pull = ack_it;
    #Q scl = 1'b1;
    #H scl = 1'b0;
    // Release mid low phase, never in the step of the next call
    #(Q / 2) sda_pull = 1'b0;
    #(Q - Q / 2);
  endtask

  // Stop: line rises under high clock
  task automatic bus_stop();
    sda_pull = 1'b1;
    #Q scl = 1'b1;
    #H sda_pull = 1'b0;
    #H;
  endtask
endmodule
`default_nettype wire

// *** verification/eit_target_tb.sv ***
// Purpose: Self-checking bench of the two-wire memory target front end
// Assumes: Serial clock slowed for the pin filters
// Notes:   Read data steps by 8'h11 on each read advance
`timescale 1ns/1ps
`default_nettype none
module eit_target_tb;
  import eit_pkg::*;

  logic           clk_sys = 1'b0;
  logic           resetn;
  logic           scl;
  logic           sda_pull;
  logic           sda;
  logic           sda_o;
  logic           sda_oe;
  logic           write_protect_n;
  logic [2:0]     strap;
  logic           wr_busy;
  logic [7:0]     rd_data = 8'h96;
  logic           rd_next;
  logic           addr_load;
  logic           wr_valid;
  eit_wr_type     wr_out;
  logic           wr_cycle_start;
  eit_status_type status;
  int             n_mismatch = 0;
  int             compares = 0;
  int             n_wv = 0;
  int             n_ws = 0;
  int             n_rn = 0;
  int             n_al = 0;

  always #4 clk_sys = ~clk_sys;
  // Pull-up wins unless someone pulls low
  assign sda = !(sda_pull || sda_oe);

  eit_bus_ctrl u_ctrl (.scl(scl), .sda_pull(sda_pull), .sda(sda));
  eit_target DUT (
    .clk_sys(clk_sys), .resetn(resetn), .scl_clk(scl), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .write_protect_n(write_protect_n),
    .chip_sel_strap_2(strap[2]), .chip_sel_strap_1(strap[1]), .chip_sel_strap_0(strap[0]),
    .wr_busy(wr_busy), .rd_data(rd_data), .rd_next(rd_next), .addr_load(addr_load),
    .wr_valid(wr_valid), .wr_out(wr_out), .wr_cycle_start(wr_cycle_start), .status(status));

  // Pulse counters; read data moves on after each advance
  always @(posedge clk_sys)
  begin
    n_wv <= n_wv + int'(wr_valid);
    n_ws <= n_ws + int'(wr_cycle_start);
    n_rn <= n_rn + int'(rd_next);
    n_al <= n_al + int'(addr_load);
    if (rd_next)
      rd_data <= rd_data + 8'h11;
  end

  task automatic chk(string what, logic [23:0] exp, logic [23:0] got);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [7:0] sel(input logic rd);
    return {EIT_DEV_TYPE, strap, rd};
  endfunction

  task automatic t_write(input logic prot);
    logic a;
    int   v0;
    int   c0;
    int   l0;
    v0 = n_wv;
    c0 = n_ws;
    l0 = n_al;
    @(posedge clk_sys);
    write_protect_n <= prot;
    repeat (12) @(posedge clk_sys);
    u_ctrl.bus_start();
    u_ctrl.put_byte(sel(1'b0), a);
    chk("select ack", 24'h1, 24'(a));
    u_ctrl.put_byte(8'h12, a);
    chk("addr hi ack", 24'h1, 24'(a));
    u_ctrl.put_byte(8'hfe, a);
    chk("addr lo ack", 24'h1, 24'(a));
    chk("write status", 24'({EIT_WDATA, 2'b10, prot}), 24'(status));
    u_ctrl.put_byte(8'h5a, a);
    chk("data ack", 24'(!prot), 24'(a));
    u_ctrl.put_byte(8'hc3, a);
    chk("data ack", 24'(!prot), 24'(a));
    u_ctrl.bus_stop();
    chk("addr loads", 24'h1, 24'(n_al - l0));
    chk("writes", prot ? 24'h0 : 24'h2, 24'(n_wv - v0));
    chk("cycles", prot ? 24'h0 : 24'h1, 24'(n_ws - c0));
    if (!prot)
      chk("last write", {16'h12ff, 8'hc3}, wr_out);
  endtask

  task automatic t_badsel();
    logic [7:0] bad [2];
    logic       a;
    bad[0] = {EIT_DEV_TYPE ^ 4'h8, strap, 1'b0};
    bad[1] = {EIT_DEV_TYPE, strap ^ 3'h2, 1'b0};
    for (int i = 0; i < 2; i++)
    begin
      u_ctrl.bus_start();
      u_ctrl.put_byte(bad[i], a);
      chk("bad select ack", 24'h0, 24'(a));
      u_ctrl.put_byte(8'h00, a);
      chk("ignored byte ack", 24'h0, 24'(a));
      chk("phase", 24'(EIT_IDLE), 24'(status.phase));
      u_ctrl.bus_stop();
    end
  endtask

  task automatic t_read();
    logic [7:0] e;
    logic [7:0] b;
    logic       a;
    int         r0;
    @(posedge clk_sys);
    write_protect_n <= 1'b1;
    repeat (12) @(posedge clk_sys);
    e = rd_data;
    r0 = n_rn;
    u_ctrl.bus_start();
    u_ctrl.put_byte(sel(1'b1), a);
    chk("read select ack", 24'h1, 24'(a));
    chk("read status", 24'({EIT_RDATA, 3'b111}), 24'(status));
    u_ctrl.get_byte(1'b1, b);
    chk("read byte 0", 24'(e), 24'(b));
    u_ctrl.get_byte(1'b0, b);
    chk("read byte 1", 24'(e + 8'h11), 24'(b));
    chk("phase after nack", 24'(EIT_IDLE), 24'(status.phase));
    u_ctrl.bus_stop();
    chk("read steps", 24'h2, 24'(n_rn - r0));
    @(posedge clk_sys);
    write_protect_n <= 1'b0;
  endtask

  task automatic t_busy();
    logic a;
    @(posedge clk_sys);
    wr_busy <= 1'b1;
    repeat (10) @(posedge clk_sys);
    u_ctrl.bus_start();
    u_ctrl.put_byte(sel(1'b0), a);
    chk("busy select ack", 24'h0, 24'(a));
    u_ctrl.bus_stop();
    @(posedge clk_sys);
    wr_busy <= 1'b0;
    repeat (10) @(posedge clk_sys);
  endtask

  task automatic t_reset_mid();
    logic a;
    u_ctrl.bus_start();
    u_ctrl.put_byte(sel(1'b0), a);
    chk("select ack", 24'h1, 24'(a));
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("phase in reset", 24'(EIT_IDLE), 24'(status.phase));
    u_ctrl.put_byte(8'h12, a);
    chk("ack in reset", 24'h0, 24'(a));
    u_ctrl.bus_stop();
    @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (10) @(posedge clk_sys);
  endtask

  task automatic stop_test();
    if (n_mismatch == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    resetn = 1'b1;
    write_protect_n = 1'b0;
    strap = 3'h5;
    wr_busy = 1'b0;
    #2 resetn = 1'b0;
    repeat (10) @(posedge clk_sys);
    chk("oe in reset", 24'h0, 24'(sda_oe));
    chk("phase in reset", 24'(EIT_IDLE), 24'(status.phase));
    chk("data out level", 24'h0, 24'(sda_o));
    resetn <= 1'b1;
    repeat (10) @(posedge clk_sys);
    t_write(1'b0);
    t_write(1'b1);
    t_badsel();
    t_read();
    t_busy();
    t_reset_mid();
    t_write(1'b0);
    stop_test();
  end

  // Hang guard, well past the expected run
  initial
  begin
    #500000;
    n_mismatch++;
    stop_test();
  end
endmodule

bind eit_target eit_target_props u_props (
  .clk_sys(clk_sys), .resetn(resetn), .scl_i(scl_i), .sda_i(sda_i), .sda_oe(sda_oe),
  .write_protect_n(write_protect_n), .wr_busy(wr_busy), .rd_next(rd_next),
  .wr_valid(wr_valid), .wr_cycle_start(wr_cycle_start), .status(status));
`default_nettype wire
